// ---- rtl/gcm_pkg.sv ----
// shared constants of the map setup controller: device register offsets,
// write sizes, codes, masks and the error codes reported to the user side.
// assumes the device takes byte offsets on a 7-bit address and a size code.
package gcm_pkg;

   // ********************************************************************
   // device register offsets
   // ********************************************************************
   localparam logic [6:0] OFS_PIXEL_IFACE_CONTROL = 7'h11;
   localparam logic [6:0] OFS_MAP_SELECTOR = 7'h12;
   localparam logic [6:0] OFS_MAP_BASE_ADDRESS = 7'h14;
   localparam logic [6:0] OFS_MAP_WIDTH_MINUS_ONE = 7'h18;
   localparam logic [6:0] OFS_MAP_HEIGHT_MINUS_ONE = 7'h1a;
   localparam logic [6:0] OFS_MAP_PIXEL_FORMAT = 7'h1c;
   localparam logic [6:0] OFS_FORE_MIX_SELECT = 7'h48;
   localparam logic [6:0] OFS_BACK_MIX_SELECT = 7'h49;
   localparam logic [6:0] OFS_DEST_COMPARE_CONTROL = 7'h4a;
   localparam logic [6:0] OFS_PLANE_WRITE_MASK = 7'h50;
   localparam logic [6:0] OFS_CARRY_CHAIN_ENABLE_MASK = 7'h54;
   localparam logic [6:0] OFS_FORE_PIXEL_VALUE = 7'h58;
   localparam logic [6:0] OFS_BACK_PIXEL_VALUE = 7'h5c;
   localparam logic [6:0] OFS_OP_WIDTH_MINUS_ONE = 7'h60;
   localparam logic [6:0] OFS_OP_HEIGHT_MINUS_ONE = 7'h62;

   // ********************************************************************
   // write sizes on the device port
   // ********************************************************************
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;

   // ********************************************************************
   // values written and limits checked
   // ********************************************************************
   localparam logic [7:0] PIXEL_IFACE_SIMPLE = 8'h00;
   localparam logic [7:0] DEST_COMPARE_OFF = 8'h04;
   localparam logic [3:0] MAP_SEL_LAST = 4'h3;
   localparam logic [7:0] FMT_BIG_ENDIAN_BIT = 8'h08;
   localparam logic [2:0] FMT_DEPTH_16 = 3'h4;
   localparam logic [7:0] MIX_LAST_CODE = 8'h15;
   localparam logic [31:0] LOW_16MB_LIMIT = 32'h0100_0000;

   // ********************************************************************
   // step counts of the two write sequences
   // ********************************************************************
   localparam logic [3:0] MAP_STEPS = 4'h5;
   localparam logic [3:0] OP_STEPS = 4'ha;

   // ********************************************************************
   // user command kinds and error codes
   // ********************************************************************
   typedef enum logic {CMD_MAP_SETUP, CMD_OP_SETUP} gcm_cmd_t;

   localparam logic [2:0] ERR_NONE = 3'h0;
   localparam logic [2:0] ERR_MAP_SEL = 3'h1;
   localparam logic [2:0] ERR_FORMAT = 3'h2;
   localparam logic [2:0] ERR_LOW_16MB = 3'h3;
   localparam logic [2:0] ERR_DIM_ZERO = 3'h4;
   localparam logic [2:0] ERR_MIX = 3'h5;

endpackage : gcm_pkg

// ---- rtl/gcm_param_check.sv ----
// combinational checks on a latched command: format legality, depth masks,
// mix legality and where a map base lies.
// assumes inputs are stable flip-flop outputs of the controller.
`timescale 1ns/1ps
module gcm_param_check #(
   parameter bit LATER_REV = 1'b1
) (
   // map fields
   input wire logic [7:0] format,
   input wire logic [31:0] base,
   // window of local video memory and the bus width flag
   input wire logic [31:0] vram_base,
   input wire logic [31:0] vram_size,
   input wire logic bus16,
   // mixes
   input wire logic [7:0] fore_mix,
   input wire logic [7:0] back_mix,
   // results
   output logic fmt_ok,
   output logic [31:0] depth_mask,
   output logic mix_ok,
   output logic in_vram,
   output logic addr_ok
);

   logic [2:0] depth;
   logic [32:0] vram_end;

   assign depth = format[2:0];
   assign vram_end = {1'b0, vram_base} + {1'b0, vram_size};

   always_comb begin
      fmt_ok = ((format & ~gcm_pkg::FMT_BIG_ENDIAN_BIT) <= {5'h00, gcm_pkg::FMT_DEPTH_16});
      // 16-bit depth only on later revision
      if (depth == gcm_pkg::FMT_DEPTH_16 && !LATER_REV) begin
         fmt_ok = 1'b0;
      end
      // all planes of the pixel size
      unique case (depth)
         3'h0: depth_mask = 32'h0000_0001;
         3'h1: depth_mask = 32'h0000_0003;
         3'h2: depth_mask = 32'h0000_000f;
         3'h3: depth_mask = 32'h0000_00ff;
         default: depth_mask = 32'h0000_ffff;
      endcase
      // logic and arithmetic mix codes only
      mix_ok = (fore_mix <= gcm_pkg::MIX_LAST_CODE) && (back_mix <= gcm_pkg::MIX_LAST_CODE);
      // local only inside base .. base + size
      in_vram = ({1'b0, base} >= {1'b0, vram_base}) && ({1'b0, base} < vram_end);
      // narrow bus reaches system memory below 16MB only
      addr_ok = in_vram || !bus16 || (base < gcm_pkg::LOW_16MB_LIMIT);
   end

endmodule : gcm_param_check

// ---- rtl/gcm_setup_ctrl.sv ----
// host-side controller that programs the map descriptors and the transfer
// parameters of a 2-D graphics coprocessor through its register port.
// assumes the device takes one write per dev_wr and answers with dev_ack.
//
// Summary of operation
// - on a 16-bit bus, system maps below 16MB, else refused.
// - map width written as pixels minus one.
// - map height written as pixels minus one.
// - pixel interface control cleared for simple operations.
// - destination compare written 04 so every pixel updates.
// - plane mask set to ones over the pixel depth.
// - carry chain mask set to ones over the pixel depth.
// - both mixes written in every operation setup.
// - transfer width written as pixels minus one.
// - transfer height written as pixels minus one.
`timescale 1ns/1ps
module gcm_setup_ctrl #(
   parameter bit LATER_REV = 1'b1
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // user command handshake
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire gcm_pkg::gcm_cmd_t cmd_kind,
   // map setup fields
   input wire logic [3:0] map_sel,
   input wire logic [31:0] map_base,
   input wire logic [15:0] map_width_px,
   input wire logic [15:0] map_height_px,
   input wire logic [7:0] map_format,
   // operation setup fields
   input wire logic [7:0] fore_mix,
   input wire logic [7:0] back_mix,
   input wire logic [31:0] fore_value,
   input wire logic [31:0] back_value,
   input wire logic [15:0] op_width_px,
   input wire logic [15:0] op_height_px,
   input wire logic [7:0] op_format,
   // system configuration
   input wire logic [31:0] vram_base,
   input wire logic [31:0] vram_size,
   input wire logic bus16,
   // results
   output logic done,
   output logic error,
   output logic [2:0] error_code,
   output logic map_in_vram,
   // device register port
   output logic dev_wr,
   output logic [6:0] dev_addr,
   output logic [1:0] dev_size,
   output logic [31:0] dev_wdata,
   input wire logic dev_ack
);

   // ********************************************************************
   // state and latched command
   // ********************************************************************
   typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_ISSUE, ST_WAIT} gcm_state_t;

   gcm_state_t state_ff, nxt_state;
   logic [3:0] step_ff, nxt_step;
   gcm_pkg::gcm_cmd_t kind_ff, nxt_kind;
   logic [3:0] sel_ff, nxt_sel;
   logic [31:0] base_ff, nxt_base;
   logic [15:0] width_ff, nxt_width;
   logic [15:0] height_ff, nxt_height;
   logic [7:0] format_ff, nxt_format;
   logic [7:0] fmix_ff, nxt_fmix;
   logic [7:0] bmix_ff, nxt_bmix;
   logic [31:0] fval_ff, nxt_fval;
   logic [31:0] bval_ff, nxt_bval;
   logic done_ff, nxt_done;
   logic error_ff, nxt_error;
   logic [2:0] ecode_ff, nxt_ecode;
   logic in_vram_ff, nxt_in_vram;
   logic wr_ff, nxt_wr;
   logic [6:0] addr_ff, nxt_addr;
   logic [1:0] size_ff, nxt_size;
   logic [31:0] wdata_ff, nxt_wdata;

   logic fmt_ok, mix_ok, in_vram, addr_ok;
   logic [31:0] depth_mask;
   logic [6:0] step_addr;
   logic [1:0] step_size;
   logic [31:0] step_data;
   logic [3:0] last_step;

   // ********************************************************************
   // helpers
   // ********************************************************************
   function automatic logic [15:0] minus_one(input logic [15:0] px);
      minus_one = px - 16'h0001;
   endfunction : minus_one

   gcm_param_check #(
      .LATER_REV(LATER_REV)
   ) u_check (
      .format(format_ff),
      .base(base_ff),
      .vram_base(vram_base),
      .vram_size(vram_size),
      .bus16(bus16),
      .fore_mix(fmix_ff),
      .back_mix(bmix_ff),
      .fmt_ok(fmt_ok),
      .depth_mask(depth_mask),
      .mix_ok(mix_ok),
      .in_vram(in_vram),
      .addr_ok(addr_ok)
   );

   // ********************************************************************
   // write list of each command
   // ********************************************************************
   always_comb begin
      step_addr = gcm_pkg::OFS_MAP_SELECTOR;
      step_size = gcm_pkg::SIZE_BYTE;
      step_data = 32'h0000_0000;
      if (kind_ff == gcm_pkg::CMD_MAP_SETUP) begin
         // selector first, then the descriptor of that map
         unique case (step_ff)
            4'h0: begin
               step_data = {28'h000_0000, sel_ff};
            end
            4'h1: begin
               step_addr = gcm_pkg::OFS_MAP_BASE_ADDRESS;
               step_size = gcm_pkg::SIZE_WORD;
               step_data = base_ff;
            end
            4'h2: begin
               step_addr = gcm_pkg::OFS_MAP_WIDTH_MINUS_ONE;
               step_size = gcm_pkg::SIZE_HALF;
               step_data = {16'h0000, minus_one(width_ff)};
            end
            4'h3: begin
               step_addr = gcm_pkg::OFS_MAP_HEIGHT_MINUS_ONE;
               step_size = gcm_pkg::SIZE_HALF;
               step_data = {16'h0000, minus_one(height_ff)};
            end
            default: begin
               step_addr = gcm_pkg::OFS_MAP_PIXEL_FORMAT;
               step_data = {24'h00_0000, format_ff};
            end
         endcase
      end else begin
         unique case (step_ff)
            4'h0: begin
               step_addr = gcm_pkg::OFS_PIXEL_IFACE_CONTROL;
               step_data = {24'h00_0000, gcm_pkg::PIXEL_IFACE_SIMPLE};
            end
            4'h1: begin
               step_addr = gcm_pkg::OFS_DEST_COMPARE_CONTROL;
               step_data = {24'h00_0000, gcm_pkg::DEST_COMPARE_OFF};
            end
            4'h2: begin
               step_addr = gcm_pkg::OFS_PLANE_WRITE_MASK;
               step_size = gcm_pkg::SIZE_WORD;
               step_data = depth_mask;
            end
            4'h3: begin
               step_addr = gcm_pkg::OFS_CARRY_CHAIN_ENABLE_MASK;
               step_size = gcm_pkg::SIZE_WORD;
               step_data = depth_mask;
            end
            4'h4: begin
               step_addr = gcm_pkg::OFS_FORE_MIX_SELECT;
               step_data = {24'h00_0000, fmix_ff};
            end
            4'h5: begin
               step_addr = gcm_pkg::OFS_BACK_MIX_SELECT;
               step_data = {24'h00_0000, bmix_ff};
            end
            4'h6: begin
               step_addr = gcm_pkg::OFS_FORE_PIXEL_VALUE;
               step_size = gcm_pkg::SIZE_WORD;
               step_data = fval_ff;
            end
            4'h7: begin
               step_addr = gcm_pkg::OFS_BACK_PIXEL_VALUE;
               step_size = gcm_pkg::SIZE_WORD;
               step_data = bval_ff;
            end
            4'h8: begin
               step_addr = gcm_pkg::OFS_OP_WIDTH_MINUS_ONE;
               step_size = gcm_pkg::SIZE_HALF;
               step_data = {16'h0000, minus_one(width_ff)};
            end
            default: begin
               step_addr = gcm_pkg::OFS_OP_HEIGHT_MINUS_ONE;
               step_size = gcm_pkg::SIZE_HALF;
               step_data = {16'h0000, minus_one(height_ff)};
            end
         endcase
      end
   end

   assign last_step = (kind_ff == gcm_pkg::CMD_MAP_SETUP) ?
      gcm_pkg::MAP_STEPS - 4'h1 : gcm_pkg::OP_STEPS - 4'h1;

   // ********************************************************************
   // sequencer
   // ********************************************************************
   always_comb begin
      nxt_state = state_ff;
      nxt_step = step_ff;
      nxt_kind = kind_ff;
      nxt_sel = sel_ff;
      nxt_base = base_ff;
      nxt_width = width_ff;
      nxt_height = height_ff;
      nxt_format = format_ff;
      nxt_fmix = fmix_ff;
      nxt_bmix = bmix_ff;
      nxt_fval = fval_ff;
      nxt_bval = bval_ff;
      nxt_done = 1'b0;
      nxt_error = 1'b0;
      nxt_ecode = ecode_ff;
      nxt_in_vram = in_vram_ff;
      nxt_wr = wr_ff;
      nxt_addr = addr_ff;
      nxt_size = size_ff;
      nxt_wdata = wdata_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (cmd_valid) begin
               nxt_kind = cmd_kind;
               // only fields of the command taken are replaced
               if (cmd_kind == gcm_pkg::CMD_MAP_SETUP) begin
                  nxt_sel = map_sel;
                  nxt_base = map_base;
                  nxt_width = map_width_px;
                  nxt_height = map_height_px;
                  nxt_format = map_format;
               end else begin
                  nxt_fmix = fore_mix;
                  nxt_bmix = back_mix;
                  nxt_fval = fore_value;
                  nxt_bval = back_value;
                  nxt_width = op_width_px;
                  nxt_height = op_height_px;
                  nxt_format = op_format;
               end
               nxt_state = ST_CHECK;
            end
         end
         ST_CHECK: begin
            nxt_step = 4'h0;
            nxt_ecode = gcm_pkg::ERR_NONE;
            if (width_ff == 16'h0000 || height_ff == 16'h0000) begin
               nxt_ecode = gcm_pkg::ERR_DIM_ZERO;
            end
            if (kind_ff == gcm_pkg::CMD_MAP_SETUP) begin
               // only mask map and maps A to C exist
               if (sel_ff > gcm_pkg::MAP_SEL_LAST) begin
                  nxt_ecode = gcm_pkg::ERR_MAP_SEL;
               end else if (!fmt_ok) begin
                  nxt_ecode = gcm_pkg::ERR_FORMAT;
               end else if (!addr_ok) begin
                  // system map at or above 16MB on narrow bus
                  nxt_ecode = gcm_pkg::ERR_LOW_16MB;
               end
               nxt_in_vram = in_vram;
            end else if (!fmt_ok) begin
               nxt_ecode = gcm_pkg::ERR_FORMAT;
            end else if (!mix_ok) begin
               nxt_ecode = gcm_pkg::ERR_MIX;
            end
            if (nxt_ecode != gcm_pkg::ERR_NONE) begin
               nxt_error = 1'b1;
               nxt_state = ST_IDLE;
            end else begin
               nxt_state = ST_ISSUE;
            end
         end
         ST_ISSUE: begin
            nxt_wr = 1'b1;
            nxt_addr = step_addr;
            nxt_size = step_size;
            nxt_wdata = step_data;
            nxt_state = ST_WAIT;
         end
         ST_WAIT: begin
            // write held until the device takes it
            if (dev_ack) begin
               nxt_wr = 1'b0;
               if (step_ff == last_step) begin
                  nxt_done = 1'b1;
                  nxt_state = ST_IDLE;
               end else begin
                  nxt_step = step_ff + 4'h1;
                  nxt_state = ST_ISSUE;
               end
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= ST_IDLE;
         step_ff <= 4'h0;
         kind_ff <= gcm_pkg::CMD_MAP_SETUP;
         sel_ff <= 4'h0;
         base_ff <= 32'h0000_0000;
         width_ff <= 16'h0000;
         height_ff <= 16'h0000;
         format_ff <= 8'h00;
         fmix_ff <= 8'h00;
         bmix_ff <= 8'h00;
         fval_ff <= 32'h0000_0000;
         bval_ff <= 32'h0000_0000;
         done_ff <= 1'b0;
         error_ff <= 1'b0;
         ecode_ff <= gcm_pkg::ERR_NONE;
         in_vram_ff <= 1'b0;
         wr_ff <= 1'b0;
         addr_ff <= 7'h00;
         size_ff <= gcm_pkg::SIZE_BYTE;
         wdata_ff <= 32'h0000_0000;
      end else begin
         state_ff <= nxt_state;
         step_ff <= nxt_step;
         kind_ff <= nxt_kind;
         sel_ff <= nxt_sel;
         base_ff <= nxt_base;
         width_ff <= nxt_width;
         height_ff <= nxt_height;
         format_ff <= nxt_format;
         fmix_ff <= nxt_fmix;
         bmix_ff <= nxt_bmix;
         fval_ff <= nxt_fval;
         bval_ff <= nxt_bval;
         done_ff <= nxt_done;
         error_ff <= nxt_error;
         ecode_ff <= nxt_ecode;
         in_vram_ff <= nxt_in_vram;
         wr_ff <= nxt_wr;
         addr_ff <= nxt_addr;
         size_ff <= nxt_size;
         wdata_ff <= nxt_wdata;
      end
   end

   // ********************************************************************
   // outputs
   // ********************************************************************
   assign cmd_ready = (state_ff == ST_IDLE);
   assign done = done_ff;
   assign error = error_ff;
   assign error_code = ecode_ff;
   assign map_in_vram = in_vram_ff;
   assign dev_wr = wr_ff;
   assign dev_addr = addr_ff;
   assign dev_size = size_ff;
   assign dev_wdata = wdata_ff;

endmodule : gcm_setup_ctrl

// ---- test/gcm_setup_props.sv ----
// checker on the setup controller ports: answer timing, write hold, sequence heads
// assumes one clock domain with the asynchronous active-low reset
`timescale 1ns/1ps
module gcm_setup_props (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // user side
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire gcm_pkg::gcm_cmd_t cmd_kind,
   input wire logic [3:0] map_sel,
   input wire logic [31:0] map_base,
   input wire logic [31:0] vram_base,
   input wire logic [31:0] vram_size,
   input wire logic done,
   input wire logic error,
   input wire logic [2:0] error_code,
   input wire logic map_in_vram,
   // device side
   input wire logic dev_wr,
   input wire logic [6:0] dev_addr,
   input wire logic [1:0] dev_size,
   input wire logic [31:0] dev_wdata,
   input wire logic dev_ack
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_map;
      cmd_valid && cmd_ready && cmd_kind == gcm_pkg::CMD_MAP_SETUP;
   endsequence
   sequence s_op;
      cmd_valid && cmd_ready && cmd_kind == gcm_pkg::CMD_OP_SETUP;
   endsequence
   chk_sel_first: assert property (s_map ##3 dev_wr |-> dev_size == gcm_pkg::SIZE_BYTE
      && dev_addr == gcm_pkg::OFS_MAP_SELECTOR && dev_wdata == {28'h0, $past(map_sel, 3)})
      else $error("map setup did not open with the selector write");
   chk_iface_first: assert property (s_op ##3 dev_wr |-> dev_wdata == 32'h0
      && dev_addr == gcm_pkg::OFS_PIXEL_IFACE_CONTROL && dev_size == gcm_pkg::SIZE_BYTE)
      else $error("op setup did not open by clearing the interface control");
   chk_vram_flag: assert property (s_map ##2 !error |-> ##1 map_in_vram ==
      ($past(map_base, 3) >= $past(vram_base, 3)
      && $past(map_base, 3) - $past(vram_base, 3) < $past(vram_size, 3)))
      else $error("local memory flag disagrees with the video window");
   chk_wr_hold: assert property (dev_wr && !dev_ack |=> dev_wr && $stable(dev_addr)
      && $stable(dev_wdata) && $stable(dev_size))
      else $error("device write changed before its acknowledge");
   chk_wr_gap: assert property (dev_wr && dev_ack |=> !dev_wr)
      else $error("device write not released after acknowledge");
   chk_answer_two: assert property ((s_map or s_op) |-> (##2 error or ##3 dev_wr))
      else $error("command neither refused nor started");
   chk_err_code: assert property (error |-> error_code != gcm_pkg::ERR_NONE && !dev_wr)
      else $error("refusal without a cause code or with a write");
   chk_done_clean: assert property (done |-> $past(dev_ack) && !dev_wr
      && error_code == gcm_pkg::ERR_NONE && !cmd_ready == 1'b0)
      else $error("done without a final acknowledge");
endmodule : gcm_setup_props

bind gcm_setup_ctrl gcm_setup_props u_props (.sys_clk, .rst_n, .cmd_valid, .cmd_ready,
   .cmd_kind, .map_sel, .map_base, .vram_base, .vram_size, .done, .error, .error_code,
   .map_in_vram, .dev_wr, .dev_addr, .dev_size, .dev_wdata, .dev_ack);

// ---- test/gcm_dev_model.sv ----
// register model of the coprocessor parameter set behind the controller port
// assumes the bench reads the stored values by hierarchy; ack delay is set by the bench
`timescale 1ns/1ps
module gcm_dev_model (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // register port
   input wire logic dev_wr,
   input wire logic [6:0] dev_addr,
   input wire logic [1:0] dev_size,
   input wire logic [31:0] dev_wdata,
   output logic dev_ack,
   // answer delay in cycles
   input wire logic [3:0] ack_dly
);
   logic [3:0] wait_cnt, sel;
   logic [31:0] base [4];
   logic [15:0] wid [4];
   logic [15:0] hgt [4];
   logic [7:0] fmt [4];
   logic [7:0] iface, dcmp, fmix, bmix;
   logic [31:0] pmask, cmask, fval, bval;
   logic [15:0] opw, oph;
   int wr_cnt;
   // storage has no reset: a missing write stays unknown and is caught
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dev_ack <= 1'b0;
         wait_cnt <= 4'h0;
         wr_cnt <= 0;
      end else begin
         dev_ack <= dev_wr && !dev_ack && wait_cnt >= ack_dly;
         wait_cnt <= (dev_wr && !dev_ack) ? wait_cnt + 4'h1 : 4'h0;
         if (dev_wr && dev_ack) begin
            wr_cnt <= wr_cnt + 1;
            case (dev_addr)
               7'h12: sel <= dev_wdata[3:0];
               7'h14: base[sel[1:0]] <= dev_wdata;
               7'h18: wid[sel[1:0]] <= dev_wdata[15:0];
               7'h1a: hgt[sel[1:0]] <= dev_wdata[15:0];
               7'h1c: fmt[sel[1:0]] <= dev_wdata[7:0];
               7'h11: iface <= dev_wdata[7:0];
               7'h4a: dcmp <= dev_wdata[7:0];
               7'h50: pmask <= dev_wdata;
               7'h54: cmask <= dev_wdata;
               7'h48: fmix <= dev_wdata[7:0];
               7'h49: bmix <= dev_wdata[7:0];
               7'h58: fval <= dev_wdata;
               7'h5c: bval <= dev_wdata;
               7'h60: opw <= dev_wdata[15:0];
               7'h62: oph <= dev_wdata[15:0];
               default: wr_cnt <= wr_cnt + 1000;
            endcase
         end
      end
   end
endmodule : gcm_dev_model

// ---- test/tb.sv ----
// bench for the map setup controller against the device register model
// assumes the checker binds itself to the controller
`timescale 1ns/1ps
module tb;
   logic sys_clk, rst_n, cmd_valid, cmd_ready, done, error, map_in_vram, bus16, dev_wr;
   logic dev_ack, got_err;
   gcm_pkg::gcm_cmd_t cmd_kind;
   logic [3:0] map_sel, ack_dly;
   logic [31:0] map_base, fore_value, back_value, vram_base, vram_size, dev_wdata;
   logic [15:0] map_width_px, map_height_px, op_width_px, op_height_px;
   logic [7:0] map_format, fore_mix, back_mix, op_format;
   logic [2:0] error_code;
   logic [6:0] dev_addr;
   logic [1:0] dev_size;
   int error_cnt, tests_run, cyc, i, n, wr_keep;
   logic [7:0] fmts [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h09, 8'h0a,
      8'h0b, 8'h0c};
   gcm_setup_ctrl dut (.sys_clk, .rst_n, .cmd_valid, .cmd_ready, .cmd_kind, .map_sel,
      .map_base, .map_width_px, .map_height_px, .map_format, .fore_mix, .back_mix,
      .fore_value, .back_value, .op_width_px, .op_height_px, .op_format, .vram_base,
      .vram_size, .bus16, .done, .error, .error_code, .map_in_vram, .dev_wr, .dev_addr,
      .dev_size, .dev_wdata, .dev_ack);
   gcm_dev_model dev (.sys_clk, .rst_n, .dev_wr, .dev_addr, .dev_size, .dev_wdata,
      .dev_ack, .ack_dly);
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // ****************************************************************
   // tasks
   // ****************************************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_sim
   // ready is high whenever idle, so one cycle of valid is taken
   task automatic run(input gcm_pkg::gcm_cmd_t k);
      wr_keep = dev.wr_cnt;
      @(negedge sys_clk);
      cmd_kind = k;
      cmd_valid = 1'b1;
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      n = 0;
      while (!(done || error) && n < 400) begin
         @(negedge sys_clk);
         n++;
      end
      got_err = error;
      if (n == 400) error_cnt++;
   endtask : run
   task automatic map(input logic [3:0] s, input logic [31:0] b, input logic [15:0] w,
      input logic [15:0] h, input logic [7:0] f);
      map_sel = s;
      map_base = b;
      map_width_px = w;
      map_height_px = h;
      map_format = f;
      run(gcm_pkg::CMD_MAP_SETUP);
   endtask : map
   task automatic op(input logic [7:0] fm, input logic [7:0] bm, input logic [31:0] fv,
      input logic [31:0] bv, input logic [15:0] w, input logic [15:0] h,
      input logic [7:0] f);
      fore_mix = fm;
      back_mix = bm;
      fore_value = fv;
      back_value = bv;
      op_width_px = w;
      op_height_px = h;
      op_format = f;
      run(gcm_pkg::CMD_OP_SETUP);
   endtask : op
   task automatic refused(input logic [2:0] code);
      chk(got_err, 1);
      chk(error_code, code);
      chk(dev.wr_cnt, wr_keep);
   endtask : refused
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      {rst_n, cmd_valid, bus16, ack_dly} = '0;
      cmd_kind = gcm_pkg::CMD_MAP_SETUP;
      {map_sel, map_base, map_width_px, map_height_px, map_format} = '0;
      {fore_mix, back_mix, fore_value, back_value, op_width_px, op_height_px, op_format} = '0;
      vram_base = 32'h0080_0000;
      vram_size = 32'h0010_0000;
      repeat (8) @(negedge sys_clk);
      rst_n = 1'b1;
      for (i = 0; i < 4; i++) map(i[3:0], 32'h0080_0000 + i * 32'h1000, 16'd640 + i[15:0],
         16'd480 + i[15:0], fmts[i + 5]);
      chk(map_in_vram, 1);
      map(4'h1, 32'h0200_0000, 16'd1024, 16'd768, 8'h0b);
      chk(map_in_vram, 0);
      chk(dev.wid[1], 32'h3ff);
      chk(dev.hgt[1], 32'h2ff);
      chk(dev.base[1], 32'h0200_0000);
      for (i = 0; i < 4; i += 2) begin
         chk(dev.base[i], 32'h0080_0000 + i * 32'h1000);
         chk(dev.wid[i], 32'h27f + i);
         chk(dev.hgt[i], 32'h1df + i);
         chk(dev.fmt[i], fmts[i + 5]);
      end
      for (i = 0; i < 10; i++) begin
         map(4'h3, 32'h0080_0000, 16'd8, 16'd8, fmts[i]);
         chk(dev.fmt[3], fmts[i]);
      end
      $display("map tests done, %0d comparisons", tests_run);
      map(4'h4, 32'h0080_0000, 16'd8, 16'd8, 8'h00);
      refused(gcm_pkg::ERR_MAP_SEL);
      map(4'h2, 32'h0080_0000, 16'd8, 16'd8, 8'h05);
      refused(gcm_pkg::ERR_FORMAT);
      map(4'h2, 32'h0080_0000, 16'd8, 16'd8, 8'h0d);
      refused(gcm_pkg::ERR_FORMAT);
      map(4'h2, 32'h0080_0000, 16'd0, 16'd8, 8'h00);
      refused(gcm_pkg::ERR_DIM_ZERO);
      bus16 = 1'b1;
      map(4'h2, 32'h0100_0000, 16'd8, 16'd8, 8'h00);
      refused(gcm_pkg::ERR_LOW_16MB);
      map(4'h2, 32'h00ff_fff0, 16'd8, 16'd8, 8'h00);
      chk(dev.base[2], 32'h00ff_fff0);
      bus16 = 1'b0;
      op(8'h16, 8'h00, 32'h0, 32'h0, 16'd8, 16'd8, 8'h03);
      refused(gcm_pkg::ERR_MIX);
      op(8'h03, 8'h00, 32'h0, 32'h0, 16'd8, 16'd0, 8'h03);
      refused(gcm_pkg::ERR_DIM_ZERO);
      $display("refusal tests done, %0d comparisons", tests_run);
      ack_dly = 4'h3;
      op(8'h03, 8'h00, 32'h5, 32'h0, 16'd100, 16'd60, 8'h03);
      chk(dev.wr_cnt, wr_keep + 10);
      chk(dev.iface, 0);
      chk(dev.dcmp, 32'h4);
      chk(dev.fval, 32'h5);
      chk(dev.opw, 32'h63);
      chk(dev.oph, 32'h3b);
      for (i = 0; i < 22; i++) begin
         ack_dly = i[3:0] & 4'h3;
         op(i[7:0], 8'd21 - i[7:0], i, ~i, 16'd1 + i[15:0], 16'd2 + i[15:0], fmts[i % 10]);
         chk(dev.fmix, i);
         chk(dev.bmix, 21 - i);
         chk(dev.pmask, (32'h1 << (32'h1 << fmts[i % 10][2:0])) - 32'h1);
         chk(dev.cmask, (32'h1 << (32'h1 << fmts[i % 10][2:0])) - 32'h1);
         chk(dev.bval, ~i);
      end
      chk(dev.base[0], 32'h0080_0000);
      $display("operation tests done, %0d comparisons", tests_run);
      end_sim();
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 30000) begin
         error_cnt++;
         end_sim();
      end
   end
endmodule : tb
